// >>> rtl/access_guard.sv
// Purpose: write-protect controller for the peripherals of one bridge
// Assumes: two-phase bridge register port, all inputs on clk_in
// Notes:   bus clock enable comes from the power manager logic
//
// Summary of operation
// - one controller instance per bus bridge
// - one independent protect flag per peripheral
// - bus clock on for banks 0,1
// - keeps working in sleep while clocked
// - debugger writes bypass protection
// - writing zero leaves the flag alone
// - writing one to clear drops protection
// - read returns flag, one means protected
// - clear at 0x00, set at 0x04
// - bank 0 flags at bits 6..1
// - bank 2 analog flags at bits 19..16
// - bank 2 timer flags at bits 15..8
// - bank 2 serial 7..2, event bit 1
`timescale 1ns/1ps
module access_guard #(
  parameter int INSTANCE = 0
) (
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic        power_clk_load_in,
  input  wire logic        power_clk_on_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [31:0] per_wr_req_in,
  input  wire logic        per_wr_debug_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic      [31:0] per_wr_en_out,
  output logic             per_wr_blocked_out,
  output logic      [31:0] flags_out,
  output logic             guard_bus_clock_out
);

  localparam logic [31:0] FLAG_MASK  = access_guard_pkg::mask_of(INSTANCE);
  localparam logic [31:0] FLAG_RESET = access_guard_pkg::reset_of(INSTANCE);
  localparam logic        CLK_RESET  =
    access_guard_pkg::CLK_ON_RESET[INSTANCE];

  logic [31:0] flags_r;
  logic [31:0] flags_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        ready_r;
  logic        ready_nxt;
  logic        err_r;
  logic        err_nxt;
  logic        clk_on_r;
  logic        clk_on_nxt;
  logic        hit_clear;
  logic        hit_set;
  logic        wr_access;

  // -------------------------------------------------------------------
  // bus clock enable
  // -------------------------------------------------------------------
  // the power manager may switch the clock at any time after reset
  always_comb begin
    clk_on_nxt = clk_on_r;
    if (power_clk_load_in) begin
      clk_on_nxt = power_clk_on_in;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      clk_on_r <= CLK_RESET;
    end else begin
      clk_on_r <= clk_on_nxt;
    end
  end

  // -------------------------------------------------------------------
  // register port
  // -------------------------------------------------------------------
  // no sleep input: only the bus clock enable stops the port
  assign hit_clear = paddr_in == access_guard_pkg::OFS_CLEAR;
  assign hit_set   = paddr_in == access_guard_pkg::OFS_SET;
  assign wr_access = psel_in & penable_in & pwrite_in & ready_r;

  always_comb begin
    ready_nxt = 1'b0;
    err_nxt   = 1'b0;
    rdata_nxt = '0;
    // answer in the access phase; with the bus clock off the port stalls
    if (clk_on_r && psel_in && !penable_in) begin
      ready_nxt = 1'b1;
      err_nxt   = ~(hit_clear | hit_set);
      if (!pwrite_in && (hit_clear || hit_set)) begin
        rdata_nxt = flags_r;
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ready_r <= 1'b0;
      err_r   <= 1'b0;
      rdata_r <= '0;
    end else begin
      ready_r <= ready_nxt;
      err_r   <= err_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // -------------------------------------------------------------------
  // protection flags
  // -------------------------------------------------------------------
  // bits outside the layout keep their reset value
  genvar b;
  generate
    for (b = 0; b < 32; b++) begin : g_flag
      always_comb begin
        flags_nxt[b] = flags_r[b];
        if (FLAG_MASK[b] && wr_access && pwdata_in[b]) begin
          if (hit_clear) begin
            flags_nxt[b] = 1'b0;
          end else if (hit_set) begin
            flags_nxt[b] = 1'b1;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      flags_r <= FLAG_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // -------------------------------------------------------------------
  // peripheral write gate
  // -------------------------------------------------------------------
  guard_write_gate #(
    .WIDTH (32)
  ) u_gate (
    .clk_in      (clk_in),
    .resetn_in   (resetn_in),
    .flags_in    (flags_r),
    .req_in      (per_wr_req_in),
    .debug_in    (per_wr_debug_in),
    .grant_out   (per_wr_en_out),
    .blocked_out (per_wr_blocked_out)
  );

  assign prdata_out          = rdata_r;
  assign pready_out          = ready_r;
  assign pslverr_out         = err_r;
  assign flags_out           = flags_r;
  assign guard_bus_clock_out = clk_on_r;

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  sequence setup_s;
    clk_on_r && psel_in && !penable_in;
  endsequence

  sequence clear_write_s;
    wr_access && hit_clear;
  endsequence

  sequence set_write_s;
    wr_access && hit_set;
  endsequence

  clear_drops_flag_a: assert property (
    clear_write_s |=>
      (flags_r & FLAG_MASK & $past(pwdata_in)) == '0)
    else $error("clear write left a flag set");

  set_raises_flag_a: assert property (
    set_write_s |=> ((flags_r & FLAG_MASK & $past(pwdata_in)) ==
      (FLAG_MASK & $past(pwdata_in))))
    else $error("set write left a flag clear");

  zero_keeps_flag_a: assert property (
    wr_access |=> ((flags_r ^ $past(flags_r)) & ~$past(pwdata_in)) == '0)
    else $error("zero bit changed a flag");

  read_returns_flags_a: assert property (
    setup_s ##0 (!pwrite_in && (hit_clear || hit_set)) |=>
      pready_out && prdata_out == $past(flags_r))
    else $error("read data differs from flags");

  unused_bits_fixed_a: assert property (
    ((flags_r ^ FLAG_RESET) & ~FLAG_MASK) == '0)
    else $error("unused bit moved");

  unmapped_error_a: assert property (
    setup_s ##0 !(hit_clear || hit_set) |=> pready_out && pslverr_out)
    else $error("unmapped access gave no error");

  clock_off_stall_a: assert property (
    // an access answered just before the clock went off may still land
    !clk_on_r && !power_clk_load_in && !pready_out |=>
      !pready_out && $stable(flags_r))
    else $error("port acted with bus clock off");

  one_cycle_answer_a: assert property (
    setup_s |=> pready_out ##1 !pready_out)
    else $error("answer not exactly one cycle");

  blocked_write_a: assert property (
    (per_wr_req_in & flags_r) != '0 && !per_wr_debug_in |=>
      per_wr_blocked_out)
    else $error("protected write not flagged");

endmodule

// >>> rtl/access_guard_pkg.sv
// Purpose: shared constants of the peripheral write-protect controller
// Assumes: one controller per peripheral bus bridge, 32-bit register bus
// Notes:   instance number selects flag layout and reset values
package access_guard_pkg;

  localparam int          ADDR_W     = 8;
  localparam int          DATA_W     = 32;
  localparam int          NUM_BANKS  = 3;

  // -------------------------------------------------------------------
  // register offsets
  // -------------------------------------------------------------------
  localparam logic [7:0]  OFS_CLEAR  = 8'h00;
  localparam logic [7:0]  OFS_SET    = 8'h04;

  // -------------------------------------------------------------------
  // flag layout per instance
  // -------------------------------------------------------------------
  localparam logic [31:0] MASK_BANK0 = 32'h0000007e;
  localparam logic [31:0] MASK_BANK1 = 32'h00000002;
  localparam logic [31:0] MASK_BANK2 = 32'h000ffffe;

  localparam logic [31:0] RESET_BANK0 = 32'h00000000;
  localparam logic [31:0] RESET_BANK1 = 32'h00000000;
  localparam logic [31:0] RESET_BANK2 = 32'h00800000;

  // bank 0 positions
  localparam int POS_EXT_INTERRUPT  = 6;
  localparam int POS_REAL_TIME      = 5;
  localparam int POS_WATCHDOG       = 4;
  localparam int POS_GENERIC_CLOCK  = 3;
  localparam int POS_SYSTEM_CONTROL = 2;
  localparam int POS_POWER_MANAGER  = 1;
  // bank 2 positions
  localparam int POS_TOUCH          = 19;
  localparam int POS_DAC            = 18;
  localparam int POS_COMPARATOR     = 17;
  localparam int POS_ADC            = 16;
  localparam int POS_TIMER_LO       = 8;
  localparam int POS_SERIAL_LO      = 2;
  localparam int POS_EVENT_SYSTEM   = 1;

  // bus clock enable state after reset, bit n for instance n
  localparam logic [2:0]  CLK_ON_RESET = 3'b011;

  function automatic logic [31:0] mask_of(input int inst);
    case (inst)
      0:       mask_of = MASK_BANK0;
      1:       mask_of = MASK_BANK1;
      default: mask_of = MASK_BANK2;
    endcase
  endfunction

  function automatic logic [31:0] reset_of(input int inst);
    case (inst)
      0:       reset_of = RESET_BANK0;
      1:       reset_of = RESET_BANK1;
      default: reset_of = RESET_BANK2;
    endcase
  endfunction

endpackage

// >>> rtl/guard_write_gate.sv
// Purpose: per-peripheral write gate driven by protection flags
// Assumes: requests and flags come from logic on clk_in
// Notes:   one cycle from request to grant or block
`timescale 1ns/1ps
module guard_write_gate #(
  parameter int WIDTH = 32
) (
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  input  wire logic [WIDTH-1:0] flags_in,
  input  wire logic [WIDTH-1:0] req_in,
  input  wire logic             debug_in,
  output logic      [WIDTH-1:0] grant_out,
  output logic                  blocked_out
);

  logic [WIDTH-1:0] grant_r;
  logic [WIDTH-1:0] grant_nxt;
  logic             blocked_r;
  logic             blocked_nxt;
  logic [WIDTH-1:0] pass;

  // -------------------------------------------------------------------
  // gating, one bit per peripheral
  // -------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      // debugger writes skip the check
      assign pass[g] = ~flags_in[g] | debug_in;
    end
  endgenerate

  always_comb begin
    grant_nxt   = req_in & pass;
    blocked_nxt = |(req_in & ~pass);
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      grant_r   <= '0;
      blocked_r <= 1'b0;
    end else begin
      grant_r   <= grant_nxt;
      blocked_r <= blocked_nxt;
    end
  end

  assign grant_out   = grant_r;
  assign blocked_out = blocked_r;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  debug_pass_a: assert property (
    debug_in |=> grant_out == $past(req_in))
    else $error("debugger write was not passed");

  protect_block_a: assert property (
    |(req_in & flags_in) && !debug_in |=> blocked_out &&
      (grant_out & $past(flags_in)) == '0)
    else $error("protected write was not blocked");

endmodule

// >>> sim/periph_side.sv
// Purpose: peripheral side model issuing register write requests
// Assumes: bench supplies random patterns, driven off the falling edge
// Notes:   requests only on flag positions that exist in the bank
`timescale 1ns/1ps
module periph_side (
  input  wire logic        clk_in,
  input  wire logic [31:0] pat_in,
  input  wire logic        dbg_in,
  output logic      [31:0] req_out,
  output logic             dbg_out
);
  initial begin
    req_out = 32'h0;
    dbg_out = 1'b0;
  end
  // one request line per protected peripheral, fresh every cycle
  always @(negedge clk_in) begin
    req_out <= pat_in & access_guard_pkg::MASK_BANK2;
    dbg_out <= dbg_in;
  end
endmodule

// >>> sim/peripheral_write_protect_test.sv
// Purpose: self-checking bench of the write-protect controller, bank 2
// Assumes: bank 2 layout, bus clock off after reset
// Notes:   integer model of the flags follows every bus write
`timescale 1ns/1ps
module peripheral_write_protect_test;
  logic        clk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic        load = 1'b0;
  logic        clk_on = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        mon_on = 1'b0;
  logic        dbg_pat = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] pat = 32'h0;
  wire  [31:0] req, prdata, wr_en, flags;
  wire         dbg, pready, pslverr, blocked, bus_clk;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  int          seed = 96462;
  int          model = access_guard_pkg::RESET_BANK2;
  int          prev = access_guard_pkg::RESET_BANK2;

  initial forever #20 clk_in = ~clk_in;

  access_guard #(.INSTANCE(2)) u_dut (
    .clk_in(clk_in), .resetn_in(resetn_in), .power_clk_load_in(load),
    .power_clk_on_in(clk_on), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .per_wr_req_in(req), .per_wr_debug_in(dbg), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .per_wr_en_out(wr_en),
    .per_wr_blocked_out(blocked), .flags_out(flags),
    .guard_bus_clock_out(bus_clk));

  periph_side u_side (.clk_in(clk_in), .pat_in(pat), .dbg_in(dbg_pat),
    .req_out(req), .dbg_out(dbg));

  task automatic check(input string name, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // two-phase register access, entered and left on falling edges
  // ---------------------------------------------------------------
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err, output logic ok);
    int n;
    @(negedge clk_in);
    psel = 1'b1;
    pwrite = wr;
    paddr = a;
    pwdata = d;
    @(negedge clk_in);
    penable = 1'b1;
    n = 0;
    while (pready !== 1'b1 && n < 8) begin
      @(negedge clk_in);
      n++;
    end
    ok = (pready === 1'b1);
    rd = prdata;
    err = pslverr;
    @(posedge clk_in);
    if (ok && wr && a == access_guard_pkg::OFS_CLEAR)
      model = model & ~(d & access_guard_pkg::MASK_BANK2);
    if (ok && wr && a == access_guard_pkg::OFS_SET)
      model = model | (d & access_guard_pkg::MASK_BANK2);
    @(negedge clk_in);
    psel = 1'b0;
    penable = 1'b0;
  endtask

  // gate answers use the flags as they stood in the request cycle
  always @(negedge clk_in) begin
    if (mon_on) begin
      check("grant", wr_en, dbg ? req : req & ~prev);
      check("blocked", {31'h0, blocked},
            {31'h0, (|(req & prev)) && !dbg});
    end
    prev = model;
    pat <= $random(seed);
    dbg_pat <= ($random(seed) & 3) == 0;
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles >= 4000) begin
      miscompares++;
      give_verdict();
    end
  end

  initial begin
    logic [31:0] rd;
    logic [31:0] got;
    logic [7:0]  a;
    logic        err, ok, wr;
    int          k;
    repeat (20) @(negedge clk_in);
    resetn_in = 1'b1;
    @(negedge clk_in);
    mon_on = 1'b1;
    check("reset flags", flags, access_guard_pkg::RESET_BANK2);
    check("clock off", {31'h0, bus_clk}, 32'h0);
    bus(1'b1, access_guard_pkg::OFS_SET, 32'hffffffff, rd, err, ok);
    check("stall", {31'h0, ok}, 32'h0);
    load = 1'b1;
    clk_on = 1'b1;
    @(negedge clk_in);
    load = 1'b0;
    check("clock on", {31'h0, bus_clk}, 32'h1);
    bus(1'b1, access_guard_pkg::OFS_SET, 32'hffffffff, rd, err, ok);
    check("set all", flags, 32'h008ffffe);
    bus(1'b1, access_guard_pkg::OFS_CLEAR, 32'h0, rd, err, ok);
    check("clear zero", flags, 32'h008ffffe);
    bus(1'b1, access_guard_pkg::OFS_CLEAR, 32'h000f0f00, rd, err, ok);
    check("clear some", flags, 32'h0080f0fe);
    for (int i = 0; i < 60; i++) begin
      k = $random(seed) & 3;
      a = (k == 3) ? 8'h08 : (k[0] ? access_guard_pkg::OFS_SET
                                   : access_guard_pkg::OFS_CLEAR);
      wr = $random(seed);
      rd = model;
      bus(wr, a, $random(seed), got, err, ok);
      if (!wr && k != 3) check("read", got, rd);
      check("error", {31'h0, err}, {31'h0, k == 3});
      check("flags", flags, model);
    end
    load = 1'b1;
    clk_on = 1'b0;
    @(negedge clk_in);
    load = 1'b0;
    bus(1'b1, access_guard_pkg::OFS_SET, 32'h000fff00, rd, err, ok);
    check("gated", {31'h0, ok}, 32'h0);
    check("held", flags, model);
    give_verdict();
  end
endmodule
